// file: verilog/sfm_defs.svh
// Constants for the serial flash mode, parameter and reset command block.
`ifndef SFM_DEFS_SVH
`define SFM_DEFS_SVH

// Opcodes.
`define SFM_OP_SEC_READ 8'h48
`define SFM_OP_SET_PARAM 8'hC0
`define SFM_OP_FAST_READ 8'h0B
`define SFM_OP_QUAD_IO_READ 8'hEB
`define SFM_OP_WRAP_READ 8'h0C
`define SFM_OP_SET_WRAP 8'h77
`define SFM_OP_QUAD_ON 8'h38
`define SFM_OP_QUAD_OFF 8'hFF
`define SFM_OP_RESET_ARM 8'h66
`define SFM_OP_RESET_GO 8'h99

// Field sizes counted in received bits.
`define SFM_OPCODE_BITS 6'h08
`define SFM_ADDR_BITS 6'h18
`define SFM_PARAM_BITS 6'h08
`define SFM_WRAP_CMD_BITS 6'h20
`define SFM_MODE_BITS 6'h08

// Read parameter layout and reset value.
`define SFM_PARAM_RESET 8'h00
`define SFM_PARAM_DUMMY_HI 5
`define SFM_PARAM_DUMMY_LO 4
`define SFM_PARAM_WRAP_HI 1
`define SFM_PARAM_WRAP_LO 0
`define SFM_WRAP_BITS_RESET 3'h0
`define SFM_WRAP_W_HI 6
`define SFM_WRAP_W_LO 4
`define SFM_MODE_RESET 8'h00

// Dummy clock and wrap length figures.
`define SFM_DUMMY_FIXED 4'h8
`define SFM_DUMMY_BASE 4'h2
`define SFM_WRAP_BASE_BYTES 8'h08

// Security area address layout.
`define SFM_SEC_AREA_HI 13
`define SFM_SEC_AREA_LO 12
`define SFM_SEC_BYTE_HI 7
`define SFM_SEC_BYTE_LO 0

// Timing.
`define SFM_CLK_PERIOD_NS 100
`define SFM_T_RST_US 30
`define SFM_RST_CYCLES ((`SFM_T_RST_US * 1000 + `SFM_CLK_PERIOD_NS - 1) / `SFM_CLK_PERIOD_NS)

`endif

// file: verilog/sfm_pkg.sv
// Types shared by the serial flash mode, parameter and reset command block.
`default_nettype none
package sfm_pkg;
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_ADDR = 3'b001,
    ST_DUMMY = 3'b010,
    ST_DATA = 3'b011,
    ST_PARAM = 3'b100,
    ST_WRAP = 3'b101,
    ST_IGNORE = 3'b110
  } sfm_state_type;

  typedef enum logic [1:0] {
    KIND_SEC = 2'b00,
    KIND_FAST = 2'b01,
    KIND_QIO = 2'b10,
    KIND_WRAP = 2'b11
  } sfm_kind_type;
endpackage : sfm_pkg
`default_nettype wire

// file: verilog/sfm_pin_sync.sv
// Two flip-flop synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none
module sfm_pin_sync #(
  parameter int WIDTH = 6
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Pins and their synchronised copies.
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] pin_sync
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic stage1;
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          stage1 <= 1'b0;
          pin_sync[i] <= 1'b0;
        end else begin
          stage1 <= pin[i];
          pin_sync[i] <= stage1;
        end
      end
    end
  endgenerate
endmodule : sfm_pin_sync
`default_nettype wire

// file: verilog/sfm_sec_mem.sv
// Storage for the four 256-byte security areas, loaded by the programming logic.
`timescale 1ns/1ns
`default_nettype none
module sfm_sec_mem #(
  parameter int AREAS = 4,
  parameter int BYTES = 256
) (
  // Clock.
  input wire logic clk,
  // Load port.
  input wire logic wr_en,
  input wire logic [$clog2(AREAS*BYTES)-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port, one cycle of latency.
  input wire logic [$clog2(AREAS*BYTES)-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:AREAS*BYTES-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : sfm_sec_mem
`default_nettype wire

// file: verilog/sfm_cmd.sv
// Serial flash command handling for security reads, read parameters, wrap, mode switch and reset.
`timescale 1ns/1ns
`default_nettype none
`include "sfm_defs.svh"
module sfm_cmd
  import sfm_pkg::*;
#(
  parameter int SEC_AREAS = 4,
  parameter int SEC_BYTES = 256
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Serial link pins.
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // Status from the program and erase engine.
  input wire logic quad_allow_bit,
  input wire logic busy_in,
  input wire logic write_latch_set,
  input wire logic write_latch_clear,
  input wire logic suspend_set,
  input wire logic suspend_clear,
  // Mode and setting outputs.
  output logic quad_command_mode,
  output logic write_latch_flag,
  output logic suspend_flag,
  output logic busy,
  output logic [7:0] read_param_bits,
  output logic [2:0] wrap_bits,
  output logic [7:0] continuous_read_bits,
  output logic sw_reset_pulse,
  // Main array read port.
  output logic [23:0] array_addr,
  input wire logic [7:0] array_data,
  // Security area load port.
  input wire logic sec_wr_en,
  input wire logic [9:0] sec_wr_addr,
  input wire logic [7:0] sec_wr_data
);
  localparam logic [8:0] RST_CYCLES = 9'(`SFM_RST_CYCLES);

  logic cs_s;
  logic sck_s;
  logic [3:0] io_s;
  logic sck_d;
  logic rise;
  logic fall;
  sfm_state_type state;
  sfm_kind_type kind;
  logic [31:0] shift_in;
  logic [5:0] bit_cnt;
  logic [31:0] next_shift;
  logic [5:0] next_bits;
  logic in_quad;
  logic [3:0] dummy_cnt;
  logic [3:0] dummy_total;
  logic [23:0] addr;
  logic [23:0] next_addr;
  logic [7:0] wrap_mask;
  logic [7:0] out_shift;
  logic [2:0] out_cnt;
  logic byte_load;
  logic [7:0] byte_src;
  logic [7:0] sec_rd;
  logic [7:0] opcode;
  logic op_done;
  logic accept;
  logic reset_armed;
  logic [8:0] reset_cnt;
  logic reset_busy;
  logic ev_arm;
  logic ev_reset;
  logic ev_quad_on;
  logic ev_quad_off;
  logic ev_param;
  logic ev_wrap;
  logic ev_mode;
  logic [1:0] wrap_code;

  sfm_pin_sync #(
    .WIDTH(6)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .pin({cs_n_pin, sck_pin, io_in}),
    .pin_sync({cs_s, sck_s, io_s})
  );

  sfm_sec_mem #(
    .AREAS(SEC_AREAS),
    .BYTES(SEC_BYTES)
  ) u_sec (
    .clk(clk),
    .wr_en(sec_wr_en),
    .wr_addr(sec_wr_addr),
    .wr_data(sec_wr_data),
    .rd_addr({addr[`SFM_SEC_AREA_HI:`SFM_SEC_AREA_LO], addr[`SFM_SEC_BYTE_HI:`SFM_SEC_BYTE_LO]}),
    .rd_data(sec_rd)
  );

  // Edges of the link clock, seen only while select is low.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= sck_s;
    end
  end

  assign rise = sck_s & ~sck_d & ~cs_s;
  assign fall = ~sck_s & sck_d & ~cs_s;

  // The 77h payload arrives four bits a clock even in serial mode.
  assign in_quad = quad_command_mode | (state == ST_WRAP);
  assign next_shift = in_quad ? {shift_in[27:0], io_s} : {shift_in[30:0], io_s[0]};
  assign next_bits = in_quad ? bit_cnt + 6'h04 : bit_cnt + 6'h01;
  assign opcode = next_shift[7:0];
  assign op_done = rise && (state == ST_OPCODE) && (next_bits == `SFM_OPCODE_BITS);

  assign reset_busy = (reset_cnt != 9'h000);
  assign accept = ~reset_busy;

  assign ev_arm = op_done && accept && (opcode == `SFM_OP_RESET_ARM);
  assign ev_reset = op_done && accept && reset_armed && (opcode == `SFM_OP_RESET_GO);
  assign ev_quad_on = op_done && accept && !quad_command_mode && quad_allow_bit && (opcode == `SFM_OP_QUAD_ON);
  assign ev_quad_off = op_done && accept && quad_command_mode && (opcode == `SFM_OP_QUAD_OFF);
  assign ev_param = rise && (state == ST_PARAM) && (next_bits == `SFM_PARAM_BITS);
  assign ev_wrap = rise && (state == ST_WRAP) && (next_bits == `SFM_WRAP_CMD_BITS);
  assign ev_mode = rise && (state == ST_DUMMY) && (kind == KIND_QIO) && (bit_cnt < `SFM_MODE_BITS)
    && (next_bits == `SFM_MODE_BITS);

  always_comb begin
    if (quad_command_mode && (kind != KIND_SEC)) begin
      dummy_total = {read_param_bits[`SFM_PARAM_DUMMY_HI:`SFM_PARAM_DUMMY_LO], 1'b0} + `SFM_DUMMY_BASE;
    end else begin
      dummy_total = `SFM_DUMMY_FIXED;
    end
  end

  assign wrap_code = read_param_bits[`SFM_PARAM_WRAP_HI:`SFM_PARAM_WRAP_LO];
  assign wrap_mask = (`SFM_WRAP_BASE_BYTES << wrap_code) - 8'h01;

  always_comb begin
    case (kind)
      KIND_SEC: begin
        next_addr = {addr[23:8], addr[7:0] + 8'h01};
      end
      KIND_WRAP: begin
        next_addr = {addr[23:8], (addr[7:0] & ~wrap_mask) | ((addr[7:0] + 8'h01) & wrap_mask)};
      end
      default: begin
        next_addr = addr + 24'h000001;
      end
    endcase
  end

  assign byte_load = fall && (state == ST_DATA) && (out_cnt == 3'h0);
  assign byte_src = (out_cnt != 3'h0) ? out_shift : ((kind == KIND_SEC) ? sec_rd : array_data);

  // Frame decoder; a rising select abandons whatever was in progress.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_OPCODE;
      kind <= KIND_SEC;
      shift_in <= 32'h00000000;
      bit_cnt <= 6'h00;
      dummy_cnt <= 4'h0;
      addr <= 24'h000000;
    end else if (cs_s) begin
      state <= ST_OPCODE;
      shift_in <= 32'h00000000;
      bit_cnt <= 6'h00;
      dummy_cnt <= 4'h0;
    end else if (rise) begin
      shift_in <= next_shift;
      bit_cnt <= next_bits;
      case (state)
        ST_OPCODE: begin
          if (next_bits == `SFM_OPCODE_BITS) begin
            bit_cnt <= 6'h00;
            state <= ST_IGNORE;
            if (accept) begin
              case (opcode)
                `SFM_OP_SEC_READ: begin
                  if (!quad_command_mode && !busy_in) begin
                    state <= ST_ADDR;
                    kind <= KIND_SEC;
                  end
                end
                `SFM_OP_FAST_READ: begin
                  if (!busy_in) begin
                    state <= ST_ADDR;
                    kind <= KIND_FAST;
                  end
                end
                `SFM_OP_QUAD_IO_READ: begin
                  if (quad_command_mode && !busy_in) begin
                    state <= ST_ADDR;
                    kind <= KIND_QIO;
                  end
                end
                `SFM_OP_WRAP_READ: begin
                  if (quad_command_mode && !busy_in) begin
                    state <= ST_ADDR;
                    kind <= KIND_WRAP;
                  end
                end
                `SFM_OP_SET_PARAM: begin
                  if (quad_command_mode) begin
                    state <= ST_PARAM;
                  end
                end
                `SFM_OP_SET_WRAP: begin
                  if (!quad_command_mode) begin
                    state <= ST_WRAP;
                  end
                end
                default: begin
                  state <= ST_IGNORE;
                end
              endcase
            end
          end
        end
        ST_ADDR: begin
          if (next_bits == `SFM_ADDR_BITS) begin
            addr <= next_shift[23:0];
            bit_cnt <= 6'h00;
            dummy_cnt <= 4'h0;
            state <= ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          dummy_cnt <= dummy_cnt + 4'h1;
          if (dummy_cnt + 4'h1 == dummy_total) begin
            state <= ST_DATA;
          end
        end
        ST_PARAM: begin
          if (next_bits == `SFM_PARAM_BITS) begin
            state <= ST_IGNORE;
          end
        end
        ST_WRAP: begin
          if (next_bits == `SFM_WRAP_CMD_BITS) begin
            state <= ST_IGNORE;
          end
        end
        default: begin
          bit_cnt <= 6'h00;
        end
      endcase
    end else if (byte_load) begin
      addr <= next_addr;
    end
  end

  // Serial output shifter; data bits change only on falling link clock edges.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
      out_shift <= 8'h00;
      out_cnt <= 3'h0;
    end else if (state != ST_DATA) begin
      io_oe <= 4'h0;
      out_cnt <= 3'h0;
    end else if (fall) begin
      if (quad_command_mode) begin
        io_out <= byte_src[7:4];
        io_oe <= 4'hF;
        out_shift <= {byte_src[3:0], 4'h0};
        out_cnt <= out_cnt + 3'h4;
      end else begin
        io_out <= {2'b00, byte_src[7], 1'b0};
        io_oe <= 4'h2;
        out_shift <= {byte_src[6:0], 1'b0};
        out_cnt <= out_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_armed <= 1'b0;
    end else if (op_done) begin
      reset_armed <= ev_arm;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_cnt <= 9'h000;
      sw_reset_pulse <= 1'b0;
    end else begin
      sw_reset_pulse <= ev_reset;
      if (ev_reset) begin
        reset_cnt <= RST_CYCLES;
      end else if (reset_busy) begin
        reset_cnt <= reset_cnt - 9'h001;
      end
    end
  end

  assign busy = busy_in | reset_busy;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      quad_command_mode <= 1'b0;
    end else if (ev_reset) begin
      quad_command_mode <= 1'b0;
    end else if (ev_quad_on) begin
      quad_command_mode <= 1'b1;
    end else if (ev_quad_off) begin
      quad_command_mode <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      read_param_bits <= `SFM_PARAM_RESET;
      wrap_bits <= `SFM_WRAP_BITS_RESET;
      continuous_read_bits <= `SFM_MODE_RESET;
    end else if (ev_reset) begin
      read_param_bits <= `SFM_PARAM_RESET;
      wrap_bits <= `SFM_WRAP_BITS_RESET;
      continuous_read_bits <= `SFM_MODE_RESET;
    end else begin
      if (ev_param) begin
        read_param_bits <= next_shift[7:0];
      end else if (ev_wrap) begin
        wrap_bits <= next_shift[`SFM_WRAP_W_HI:`SFM_WRAP_W_LO];
        read_param_bits[`SFM_PARAM_WRAP_HI:`SFM_PARAM_WRAP_LO] <= next_shift[5:4];
      end
      if (ev_mode) begin
        continuous_read_bits <= next_shift[7:0];
      end
    end
  end

  // cleared by reset
  // A set arriving with a clear wins, so an event in the clearing cycle is kept.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      write_latch_flag <= 1'b0;
      suspend_flag <= 1'b0;
    end else if (ev_reset) begin
      write_latch_flag <= 1'b0;
      suspend_flag <= 1'b0;
    end else begin
      if (write_latch_set) begin
        write_latch_flag <= 1'b1;
      end else if (write_latch_clear) begin
        write_latch_flag <= 1'b0;
      end
      if (suspend_set) begin
        suspend_flag <= 1'b1;
      end else if (suspend_clear) begin
        suspend_flag <= 1'b0;
      end
    end
  end

  assign array_addr = addr;
endmodule : sfm_cmd
`default_nettype wire

// file: bench/sfm_cmd_properties.sv
// Concurrent checks on the ports of the serial flash command block.
`timescale 1ns/1ns
`default_nettype none
module sfm_cmd_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Link side.
  input wire logic cs_n_pin,
  input wire logic [3:0] io_oe,
  // Status and settings.
  input wire logic quad_allow_bit,
  input wire logic busy_in,
  input wire logic quad_command_mode,
  input wire logic write_latch_flag,
  input wire logic suspend_flag,
  input wire logic busy,
  input wire logic [7:0] read_param_bits,
  input wire logic [2:0] wrap_bits,
  input wire logic [7:0] continuous_read_bits,
  input wire logic sw_reset_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Counts the reset interval from the pulse cycle; 12Ch is the first cycle after it.
  logic [8:0] rst_cnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_cnt <= 9'h000;
    end else if (sw_reset_pulse) begin
      rst_cnt <= 9'h001;
    end else if (rst_cnt != 9'h000 && rst_cnt != 9'h12C) begin
      rst_cnt <= rst_cnt + 9'h001;
    end else begin
      rst_cnt <= 9'h000;
    end
  end
  sequence s_link_idle;
    cs_n_pin [*5];
  endsequence
  sequence s_settings_cleared;
    read_param_bits == 8'h00 && wrap_bits == 3'h0 && continuous_read_bits == 8'h00;
  endsequence
  sequence s_flags_cleared;
    !quad_command_mode && !write_latch_flag && !suspend_flag;
  endsequence
  property p_busy_follows; busy_in |-> busy; endproperty
  a_busy_follows: assert property (p_busy_follows) else $error("busy low while engine runs");
  property p_reset_clears; sw_reset_pulse |=> s_settings_cleared ##0 s_flags_cleared; endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset left settings");
  property p_reset_busy; rst_cnt != 9'h000 && rst_cnt < 9'h12C |-> busy; endproperty
  a_reset_busy: assert property (p_reset_busy) else $error("busy dropped in reset interval");
  property p_reset_ends; rst_cnt == 9'h12C |-> busy == busy_in; endproperty
  a_reset_ends: assert property (p_reset_ends) else $error("reset interval too long");
  property p_idle_no_drive; s_link_idle |-> io_oe == 4'h0; endproperty
  a_idle_no_drive: assert property (p_idle_no_drive) else $error("driving with select high");
  property p_idle_mode_held; s_link_idle |=> $stable(quad_command_mode) && $stable(read_param_bits); endproperty
  a_idle_mode_held: assert property (p_idle_mode_held) else $error("mode changed outside frame");
  property p_quad_entry;
    $rose(quad_command_mode) |-> $past(quad_allow_bit) && (!$past(busy) || $past(busy_in)) && $stable(wrap_bits)
      && $stable(write_latch_flag) && $stable(suspend_flag);
  endproperty
  a_quad_entry: assert property (p_quad_entry) else $error("bad quad mode entry");
  property p_quad_exit;
    $fell(quad_command_mode) && !sw_reset_pulse |-> $stable(wrap_bits)
      && $stable(write_latch_flag) && $stable(suspend_flag);
  endproperty
  a_quad_exit: assert property (p_quad_exit) else $error("quad exit lost settings");
  property p_param_in_quad;
    $changed(read_param_bits[5:4]) |-> $past(quad_command_mode) || read_param_bits[5:4] == 2'h0;
  endproperty
  a_param_in_quad: assert property (p_param_in_quad) else $error("dummy code set in serial mode");
endmodule : sfm_cmd_checker
bind sfm_cmd sfm_cmd_checker sfm_cmd_checker_inst (.clk, .arst_n, .cs_n_pin, .io_oe, .quad_allow_bit,
  .busy_in, .quad_command_mode, .write_latch_flag, .suspend_flag, .busy, .read_param_bits, .wrap_bits,
  .continuous_read_bits, .sw_reset_pulse);
`default_nettype wire

// file: bench/sfm_host_model.sv
// Host controller model that drives frames on the serial link.
`timescale 1ns/1ns
`default_nettype none
module sfm_host_model (
  // Clock.
  input wire logic clk,
  // Link pins.
  output logic cs_n,
  output logic sck,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    io_in = 4'hA;
  end
  // bits change while the link clock is low.
  task automatic xfer(input logic [63:0] tx, input int ns, input int nq, input int nr, input bit rq,
      output logic [31:0] rx, output logic [3:0] oe);
    int p;
    p = 63;
    rx = 32'h0;
    oe = 4'h0;
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < ns + nq + nr; i++) begin
      // Released lanes toggle so a stale value never looks valid.
      if (i < ns) begin
        io_in <= {~io_in[3:1], tx[p]};
        p = p - 1;
      end else if (i < ns + nq) begin
        io_in <= tx[p -: 4];
        p = p - 4;
      end else begin
        io_in <= ~io_in;
      end
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      if (i >= ns + nq) begin
        rx = rq ? {rx[27:0], io_out} : {rx[30:0], io_out[1]};
        oe = oe | io_oe;
      end
      sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    io_in <= ~io_in;
    repeat (8) @(posedge clk);
  endtask : xfer
endmodule : sfm_host_model
`default_nettype wire

// file: bench/sfm_cmd_test.sv
// Self-checking bench for the serial flash command block.
`timescale 1ns/1ns
`default_nettype none
module sfm_cmd_test;
  typedef struct {
    logic allow;
    int ns;
    int nq;
    logic [63:0] tx;
    logic mode;
    logic [7:0] par;
    logic [2:0] wrap;
  } sfm_row_type;
  logic clk, arst_n, cs_n_pin, sck_pin, quad_allow_bit, busy_in, sec_wr_en, sw_reset_pulse;
  logic write_latch_set, write_latch_clear, suspend_set, suspend_clear, busy;
  logic quad_command_mode, write_latch_flag, suspend_flag;
  logic [3:0] io_in, io_out, io_oe, oe;
  logic [7:0] read_param_bits, continuous_read_bits, array_data, sec_wr_data;
  logic [2:0] wrap_bits;
  logic [23:0] array_addr, b;
  logic [9:0] sec_wr_addr;
  logic [31:0] rx, exp;
  logic [9:0] sa [4] = '{10'h2FE, 10'h2FF, 10'h200, 10'h300};
  logic [7:0] sd [4] = '{8'hA5, 8'h3C, 8'h96, 8'h0F};
  int num_errors = 0;
  int num_checks = 0;
  int pulses = 0;
  sfm_row_type rows [7];
  sfm_cmd sfm_cmd_inst (.clk, .arst_n, .cs_n_pin, .sck_pin, .io_in, .io_out, .io_oe, .quad_allow_bit,
    .busy_in, .write_latch_set, .write_latch_clear, .suspend_set, .suspend_clear, .quad_command_mode,
    .write_latch_flag, .suspend_flag, .busy, .read_param_bits, .wrap_bits, .continuous_read_bits,
    .sw_reset_pulse, .array_addr, .array_data, .sec_wr_en, .sec_wr_addr, .sec_wr_data);
  sfm_host_model sfm_host_model_inst (.clk, .cs_n(cs_n_pin), .sck(sck_pin), .io_in, .io_out, .io_oe);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Array stand-in answers one cycle after the address moves.
  always @(posedge clk) begin
    array_data <= array_addr[7:0] ^ 8'h5A;
    if (sw_reset_pulse === 1'b1) pulses++;
  end
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk
  task automatic run(input logic [63:0] tx, input int ns, input int nq, input int nr, input bit rq);
    sfm_host_model_inst.xfer(tx, ns, nq, nr, rq, rx, oe);
  endtask : run
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    {arst_n, quad_allow_bit, busy_in, sec_wr_en, write_latch_set, write_latch_clear} = 6'h00;
    {suspend_set, suspend_clear, sec_wr_data, sec_wr_addr} = 20'h0;
    rows = '{'{1'b0, 16, 0, {8'hC0, 8'h30, 48'h0}, 1'b0, 8'h00, 3'h0},
      '{1'b0, 8, 8, {8'h77, 32'h70, 24'h0}, 1'b0, 8'h03, 3'h7},
      '{1'b0, 8, 0, {8'h38, 56'h0}, 1'b0, 8'h03, 3'h7},
      '{1'b1, 8, 0, {8'h38, 56'h0}, 1'b1, 8'h03, 3'h7},
      '{1'b1, 0, 4, {8'hC0, 8'h21, 48'h0}, 1'b1, 8'h21, 3'h7},
      '{1'b1, 0, 10, {8'h77, 32'h70, 24'h0}, 1'b1, 8'h21, 3'h7},
      '{1'b1, 0, 2, {8'hFF, 56'h0}, 1'b0, 8'h21, 3'h7}};
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({read_param_bits, wrap_bits, quad_command_mode} === 12'h0, "power-on state");
    sec_wr_en <= 1'b1;
    foreach (sa[i]) begin
      sec_wr_addr <= sa[i];
      sec_wr_data <= sd[i];
      @(posedge clk);
    end
    sec_wr_en <= 1'b0;
    // read wraps from the last byte of area two back to its first byte.
    run({8'h48, 24'h0020FE, 32'h0}, 40, 0, 24, 1'b0);
    chk(rx[23:0] === 24'hA53C96 && oe === 4'h2, "security read");
    busy_in <= 1'b1;
    run({8'h48, 24'h0020FE, 32'h0}, 40, 0, 24, 1'b0);
    chk(oe === 4'h0 && busy === 1'b1, "security read while busy");
    busy_in <= 1'b0;
    run({8'h0B, 24'h0000FF, 32'h0}, 40, 0, 16, 1'b0);
    chk(rx[15:0] === 16'hA55A && oe === 4'h2, "serial fast read");
    write_latch_set <= 1'b1;
    suspend_set <= 1'b1;
    @(posedge clk);
    write_latch_set <= 1'b0;
    suspend_set <= 1'b0;
    foreach (rows[i]) begin
      quad_allow_bit <= rows[i].allow;
      run(rows[i].tx, rows[i].ns, rows[i].nq, 0, 1'b0);
      chk({quad_command_mode, read_param_bits, wrap_bits} === {rows[i].mode, rows[i].par, rows[i].wrap}, "row");
    end
    chk(write_latch_flag === 1'b1 && suspend_flag === 1'b1, "flags kept over mode change");
    // a foreign command between the pair disarms it.
    run({8'h38, 56'h0}, 8, 0, 0, 1'b0);
    run({8'hC0, 8'h21, 48'h0}, 0, 4, 0, 1'b0);
    run({8'hEB, 24'h000010, 8'hA5, 24'h0}, 0, 14, 4, 1'b1);
    chk(rx[15:0] === 16'h4A4B && continuous_read_bits === 8'hA5 && oe === 4'hF, "quad io read");
    run({8'h66, 56'h0}, 0, 2, 0, 1'b0);
    run({8'hC0, 8'h33, 48'h0}, 0, 4, 0, 1'b0);
    run({8'h99, 56'h0}, 0, 2, 0, 1'b0);
    chk(pulses == 0 && read_param_bits === 8'h33, "disarmed reset");
    run({8'h66, 56'h0}, 0, 2, 0, 1'b0);
    run({8'h99, 56'h0}, 0, 2, 0, 1'b0);
    chk(pulses == 1 && busy === 1'b1, "quad mode reset");
    chk({quad_command_mode, write_latch_flag, suspend_flag, read_param_bits, wrap_bits, continuous_read_bits} === 22'h0,
      "reset state");
    run({8'h38, 56'h0}, 8, 0, 0, 1'b0);
    chk(quad_command_mode === 1'b0 && busy === 1'b1, "command in reset interval");
    for (int n = 0; n < 400 && busy !== 1'b0; n++) @(posedge clk);
    run({8'h38, 56'h0}, 8, 0, 0, 1'b0);
    chk(quad_command_mode === 1'b1, "quad entry after reset");
    // dummy count set again before each wrapped read.
    for (int d = 0; d < 4; d++) begin
      run({8'hC0, 2'h0, d[1:0], 2'h0, d[1:0], 48'h0}, 0, 4, 0, 1'b0);
      b = 24'((8 << d) - 2);
      exp = {b[7:0] ^ 8'h5A, (b[7:0] + 8'h01) ^ 8'h5A, 8'h5A, 8'h5B};
      run({8'h0C, b, 32'h0}, 0, 10 + 2 * d, 8, 1'b1);
      chk(rx === exp && oe === 4'hF, "wrapped read");
    end
    run({8'hFF, 56'h0}, 0, 2, 0, 1'b0);
    {write_latch_set, write_latch_clear, suspend_set, suspend_clear} <= 4'hF;
    @(posedge clk);
    {write_latch_set, write_latch_clear, suspend_set, suspend_clear} <= 4'h0;
    @(posedge clk);
    chk(write_latch_flag === 1'b1 && suspend_flag === 1'b1, "set wins over clear");
    {write_latch_set, write_latch_clear, suspend_set, suspend_clear} <= 4'h5;
    @(posedge clk);
    {write_latch_set, write_latch_clear, suspend_set, suspend_clear} <= 4'h0;
    @(posedge clk);
    chk(write_latch_flag === 1'b0 && suspend_flag === 1'b0 && busy === 1'b0, "idle before reset");
    run({8'h66, 56'h0}, 8, 0, 0, 1'b0);
    run({8'h99, 56'h0}, 8, 0, 0, 1'b0);
    chk(pulses == 2 && read_param_bits === 8'h00, "serial mode reset");
    tally_and_finish();
  end
endmodule : sfm_cmd_test
`default_nettype wire
